// ### test/bus_peer.sv
// behavioural second device on the two-wire bus, clocking bytes
`timescale 1ns/10ps
module bus_peer (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    sda_o = 1'b0;
    #62.5 scl_o = 1'b0;
    #62.5;
  endtask : start
  // clocks f..n-1, msb first; data moves mid low phase; ninth bit released; low may be stretched by a held clock
  task automatic clocks(input logic [7:0] b, input int f, input int n, output logic last);
    for (int i = f; i < n; i++) begin
      #31.25 sda_o = (i < 8) ? b[3'(7 - i)] : 1'b1;
      #31.25 scl_o = 1'b1;
      repeat (200) if (!scl_w) #10;
      last = sda_w;
      #62.5 scl_o = 1'b0;
    end
  endtask : clocks
  task automatic stop();
    sda_o = 1'b0;
    #62.5 scl_o = 1'b1;
    #62.5 sda_o = 1'b1;
    #62.5;
  endtask : stop
endmodule : bus_peer

// ### test/i2c_wait_and_ack_control_tb_top.sv
// testbench for the two-wire bus wait and acknowledge control
`timescale 1ns/10ps
module i2c_wait_and_ack_control_tb_top;
  logic        clk, nrst, psel, penable, pwrite, match, ext;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ctrl;
  logic        pready, pslverr, scl_oe, sda_oe, irq, scl_p, sda_p, scl_o, sda_o, err, ack;
  wire logic   scl_w = scl_p & ~(scl_oe & ~scl_o);
  wire logic   sda_w = sda_p & ~(sda_oe & ~sda_o);
  int          bad_count, num_checks;

  wait_ack_ctrl wait_ack_ctrl_i (
    .CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl_w), .SCL_O(scl_o),
    .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .ADDR_MATCH_I(match), .EXT_CODE_I(ext), .IRQ_O(irq)
  );
  bus_peer bus_peer_i (.scl_w(scl_w), .sda_w(sda_w), .scl_o(scl_p), .sda_o(sda_p));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_pin(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s %h", $time, m, got);
    end
  endtask : chk_reg

  ////////////////////////////////////////////////////////////////////////////////
  // reference model: wait point (0 none) and acknowledge of one byte
  function automatic int exp_wait(int ad, int mst, int ex, int en, int wps);
    if (en == 0) return 0;
    if (ad != 0) return (mst == 0 && ex != 0) ? 8 : 9;
    return (wps != 0) ? 9 : 8;
  endfunction : exp_wait
  function automatic logic exp_ack(int ad, int ex, int en, int ae, int tx);
    if (en == 0 || tx != 0) return 1'b0;
    return (ad != 0 && ex == 0) ? 1'b1 : ae[0];
  endfunction : exp_ack
  // checks wait, interrupt and status, then releases the wait
  task automatic settle(input logic hit);
    repeat (10) @(posedge clk);
    chk_pin(scl_oe, hit, "wait");
    chk_pin(irq, hit, "irq");
    apb(1'b0, wait_ack_pkg::INT_STAT_OFS, 32'h0);
    chk_reg(rd & 32'h1, {31'h0, hit}, "int stat");
    if (hit) begin
      apb(1'b1, wait_ack_pkg::INT_STAT_OFS, 32'h7);
      apb(1'b1, wait_ack_pkg::CTRL_OFS, ctrl | 32'h8);
      repeat (3) @(posedge clk);
      chk_pin(scl_oe, 1'b0, "release");
      apb(1'b0, wait_ack_pkg::CTRL_OFS, 32'h0);
      chk_reg(rd, ctrl, "ctrl");
    end
  endtask : settle
  task automatic xfer(input int ad, input int mst, input int ex, input int en,
                      input int ae, input int wps);
    logic [7:0] b;
    int w;
    b = 8'($urandom_range(255));
    w = exp_wait(ad, mst, ex, en, wps);
    bus_peer_i.clocks(b, 0, 8, ack);
    settle(w == 8);
    bus_peer_i.clocks(b, 8, 9, ack);
    chk_pin(~ack, exp_ack(ad, ex, en, ae, mst), "ack");
    settle(w == 9);
  endtask : xfer
  task automatic run_case(input int mst, input int ex, input int en, input int ae,
                          input int wps);
    ctrl = {26'h0, mst[0], mst[0], 1'b0, ae[0], wps[0], en[0]};
    apb(1'b1, wait_ack_pkg::CTRL_OFS, ctrl);
    match <= (ex == 0);
    ext   <= (ex != 0);
    bus_peer_i.start();
    xfer(1, mst, ex, en, ae, wps);
    xfer(0, mst, ex, en, ae, wps);
    bus_peer_i.stop();
    $display("case done m%0d x%0d e%0d a%0d w%0d", mst, ex, en, ae, wps);
  endtask : run_case
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: timeout", $time);
    results();
  end
  initial begin
    {nrst, psel, penable, pwrite, match, ext} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(75240));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, wait_ack_pkg::CTRL_OFS, 32'h0);
    chk_reg(rd, 32'h0, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk_pin(err, 1'b1, "unmapped");
    apb(1'b1, wait_ack_pkg::INT_MASK_OFS, 32'h1);
    run_case(0, 0, 1, 1, 0);
    run_case(0, 0, 1, 0, 1);
    run_case(0, 1, 1, 1, 1);
    run_case(0, 1, 1, 0, 0);
    run_case(1, 0, 1, 0, 0);
    run_case(0, 0, 0, 1, 1);
    results();
  end
endmodule : i2c_wait_and_ack_control_tb_top

// ### verilog/wait_ack_ctrl.sv
// wait insertion, transfer interrupt and acknowledge drive for a two-wire bus unit
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module wait_ack_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  input  wire logic        ADDR_MATCH_I,
  input  wire logic        EXT_CODE_I,
  output logic             IRQ_O
);
  wait_ack_pkg::ctrl_t               ctrl_reg;
  wait_ack_pkg::phase_t              phase_reg;
  logic [3:0]                        cnt_reg;
  logic                              wait_reg;
  logic                              ext_flag_reg;
  logic                              sda_oe_reg;
  logic                              lead_fall_reg;
  logic [wait_ack_pkg::NUM_INT-1:0]  int_stat_reg;
  logic [wait_ack_pkg::NUM_INT-1:0]  int_mask_reg;
  logic [wait_ack_pkg::NUM_INT-1:0]  int_ev;
  logic [31:0]                       prdata_reg;
  logic [1:0]                        scl_sync_reg;
  logic [1:0]                        sda_sync_reg;
  logic                              scl_prev_reg;
  logic                              sda_prev_reg;
  logic                              scl_fall;
  logic                              start_det;
  logic                              stop_det;
  logic                              en;
  logic                              wr_acc;
  logic                              setup;
  logic                              mapped;
  logic                              wait_set;
  logic                              ack_next;
  logic [3:0]                        cnt_next;

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge detection
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (CE_I) begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[0], SDA_I};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign en        = ctrl_reg.bus_unit_enable;
  assign scl_fall  = CE_I && en && scl_prev_reg && !scl_sync_reg[1];
  assign start_det = CE_I && en && scl_sync_reg[1] && scl_prev_reg
                     && sda_prev_reg && !sda_sync_reg[1];
  assign stop_det  = CE_I && en && scl_sync_reg[1] && scl_prev_reg
                     && !sda_prev_reg && sda_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign setup     = PSEL_I && !PENABLE_I;
  assign wr_acc    = CE_I && PSEL_I && PENABLE_I && PWRITE_I;
  assign mapped    = (PADDR_I == wait_ack_pkg::CTRL_OFS) || (PADDR_I == wait_ack_pkg::STAT_OFS)
                     || (PADDR_I == wait_ack_pkg::INT_STAT_OFS)
                     || (PADDR_I == wait_ack_pkg::INT_MASK_OFS);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O  = prdata_reg;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prdata_reg <= wait_ack_pkg::ZERO_WORD;
    end else if (CE_I && setup) begin
      case (PADDR_I)
        wait_ack_pkg::CTRL_OFS:     prdata_reg <= {26'h0, ctrl_reg};
        wait_ack_pkg::STAT_OFS:     prdata_reg <= {23'h0, phase_reg, cnt_reg, ext_flag_reg,
                                                   sda_oe_reg, wait_reg};
        wait_ack_pkg::INT_STAT_OFS: prdata_reg <= {29'h0, int_stat_reg};
        wait_ack_pkg::INT_MASK_OFS: prdata_reg <= {29'h0, int_mask_reg};
        default:                    prdata_reg <= wait_ack_pkg::ZERO_WORD;
      endcase
    end
  end

  // control settings change only by software write; release request self-clears
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_reg <= wait_ack_pkg::CTRL_RESET;
    end else if (wr_acc && PADDR_I == wait_ack_pkg::CTRL_OFS) begin
      ctrl_reg <= wait_ack_pkg::ctrl_t'(PWDATA_I[5:0]);
    end else if (CE_I && ctrl_reg.wait_release_request) begin
      ctrl_reg.wait_release_request <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // byte framing: address byte after start, then data bytes
  assign cnt_next = (cnt_reg == wait_ack_pkg::CNT_NINTH) ? wait_ack_pkg::CNT_ZERO
                    : cnt_reg + 4'h1;

  // the clock fall that completes a start condition is not a bit clock
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lead_fall_reg <= 1'b0;
    end else if (CE_I) begin
      if (!en || stop_det) begin
        lead_fall_reg <= 1'b0;
      end else if (start_det) begin
        lead_fall_reg <= 1'b1;
      end else if (scl_fall) begin
        lead_fall_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      phase_reg <= wait_ack_pkg::PH_IDLE;
      cnt_reg   <= wait_ack_pkg::CNT_ZERO;
    end else if (CE_I) begin
      if (!en || stop_det) begin
        phase_reg <= wait_ack_pkg::PH_IDLE;
        cnt_reg   <= wait_ack_pkg::CNT_ZERO;
      end else if (start_det) begin
        phase_reg <= wait_ack_pkg::PH_ADDR;
        cnt_reg   <= wait_ack_pkg::CNT_ZERO;
      end else if (scl_fall && !lead_fall_reg && phase_reg != wait_ack_pkg::PH_IDLE) begin
        cnt_reg <= cnt_next;
        if (phase_reg == wait_ack_pkg::PH_ADDR && cnt_reg == wait_ack_pkg::CNT_EIGHTH
            && !ctrl_reg.master_mode && !ADDR_MATCH_I && !EXT_CODE_I) begin
          phase_reg <= wait_ack_pkg::PH_SKIP;
        end else if (phase_reg == wait_ack_pkg::PH_ADDR
                     && cnt_reg == wait_ack_pkg::CNT_NINTH) begin
          phase_reg <= wait_ack_pkg::PH_DATA;
        end
      end
    end
  end

  // extension code flag
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ext_flag_reg <= 1'b0;
    end else if (CE_I) begin
      if (!en || start_det || stop_det) begin
        ext_flag_reg <= 1'b0;
      end else if (scl_fall && phase_reg == wait_ack_pkg::PH_ADDR && !ctrl_reg.master_mode
                   && cnt_reg == wait_ack_pkg::CNT_EIGHTH && EXT_CODE_I) begin
        ext_flag_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wait points
  always_comb begin
    wait_set = 1'b0;
    if (scl_fall) begin
      case (phase_reg)
        wait_ack_pkg::PH_ADDR: begin
          if (ctrl_reg.master_mode) begin
            wait_set = (cnt_reg == wait_ack_pkg::CNT_NINTH);
          end else if (cnt_reg == wait_ack_pkg::CNT_EIGHTH) begin
            wait_set = EXT_CODE_I;
          end else if (cnt_reg == wait_ack_pkg::CNT_NINTH) begin
            wait_set = !ext_flag_reg;
          end
        end
        wait_ack_pkg::PH_DATA: begin
          if (ctrl_reg.wait_point_select) begin
            wait_set = (cnt_reg == wait_ack_pkg::CNT_NINTH);
          end else begin
            wait_set = (cnt_reg == wait_ack_pkg::CNT_EIGHTH);
          end
        end
        default: wait_set = 1'b0;
      endcase
    end
  end

  // clock held low while waiting, released by software
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wait_reg <= 1'b0;
    end else if (CE_I) begin
      if (!en) begin
        wait_reg <= 1'b0;
      end else if (wait_set) begin
        wait_reg <= 1'b1;
      end else if (ctrl_reg.wait_release_request) begin
        wait_reg <= 1'b0;
      end
    end
  end

  assign SCL_O    = 1'b0;
  assign SCL_OE_O = wait_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge drive in the ninth clock period
  always_comb begin
    ack_next = 1'b0;
    if (en && cnt_reg == wait_ack_pkg::CNT_NINTH) begin
      case (phase_reg)
        wait_ack_pkg::PH_ADDR: begin
          if (!ctrl_reg.master_mode) begin
            ack_next = ext_flag_reg ? ctrl_reg.ack_drive_enable : ADDR_MATCH_I;
          end
        end
        wait_ack_pkg::PH_DATA: ack_next = ctrl_reg.ack_drive_enable && !ctrl_reg.tx_dir;
        default:               ack_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sda_oe_reg <= 1'b0;
    end else if (CE_I) begin
      sda_oe_reg <= ack_next;
    end
  end

  assign SDA_O    = 1'b0;
  assign SDA_OE_O = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  assign int_ev[wait_ack_pkg::INT_XFER]  = wait_set;
  assign int_ev[wait_ack_pkg::INT_START] = start_det;
  assign int_ev[wait_ack_pkg::INT_STOP]  = stop_det;

  genvar gi;
  generate
    for (gi = 0; gi < wait_ack_pkg::NUM_INT; gi++) begin : g_int
      always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          int_stat_reg[gi] <= 1'b0;
        end else if (int_ev[gi]) begin
          int_stat_reg[gi] <= 1'b1;
        end else if (wr_acc && PADDR_I == wait_ack_pkg::INT_STAT_OFS && PWDATA_I[gi]) begin
          int_stat_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      int_mask_reg <= '0;
    end else if (wr_acc && PADDR_I == wait_ack_pkg::INT_MASK_OFS) begin
      int_mask_reg <= PWDATA_I[wait_ack_pkg::NUM_INT-1:0];
    end
  end

  assign IRQ_O = |(int_stat_reg & int_mask_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I || !CE_I);

  sequence s_data_fall(logic [3:0] c);
    en && scl_fall && phase_reg == wait_ack_pkg::PH_DATA && cnt_reg == c;
  endsequence
  sequence s_addr_fall(logic [3:0] c);
    en && scl_fall && phase_reg == wait_ack_pkg::PH_ADDR && cnt_reg == c;
  endsequence

  a_wait_eighth_data: assert property (
    s_data_fall(4'h7) ##0 !ctrl_reg.wait_point_select |=> SCL_OE_O && int_stat_reg[0])
    else $error("no wait or interrupt at eighth falling edge");
  a_wait_ninth_data: assert property (
    s_data_fall(4'h8) ##0 ctrl_reg.wait_point_select |=> SCL_OE_O && int_stat_reg[0])
    else $error("no wait or interrupt at ninth falling edge");
  a_addr_ignores_select: assert property (
    s_addr_fall(4'h7) ##0 ctrl_reg.master_mode && !wait_reg |=> !wait_reg)
    else $error("address byte used the wait point setting");
  a_master_addr_wait: assert property (
    s_addr_fall(4'h8) ##0 ctrl_reg.master_mode |=> wait_reg ##1 phase_reg == wait_ack_pkg::PH_DATA
    || !en || stop_det || start_det || $past(stop_det))
    else $error("master missed wait after address byte");
  a_slave_addr_ack: assert property (
    en && phase_reg == wait_ack_pkg::PH_ADDR && cnt_reg == 4'h8 && !ctrl_reg.master_mode
    && !ext_flag_reg && ADDR_MATCH_I |=> SDA_OE_O)
    else $error("matched address not acknowledged");
  a_ext_code_wait: assert property (
    s_addr_fall(4'h7) ##0 !ctrl_reg.master_mode && EXT_CODE_I |=> wait_reg && ext_flag_reg)
    else $error("no wait at eighth edge after extension code");
  a_settings_hold: assert property (
    !(wr_acc && PADDR_I == wait_ack_pkg::CTRL_OFS)
    |=> $stable(ctrl_reg.wait_point_select) && $stable(ctrl_reg.ack_drive_enable))
    else $error("control setting changed without a write");
  a_disabled_quiet: assert property (
    !en |=> !SCL_OE_O && !SDA_OE_O)
    else $error("pins driven while unit disabled");
  a_data_ack_drive: assert property (
    en && phase_reg == wait_ack_pkg::PH_DATA && cnt_reg == 4'h8 && !ctrl_reg.tx_dir
    |=> SDA_OE_O == $past(ctrl_reg.ack_drive_enable))
    else $error("acknowledge drive does not follow enable");
  a_ext_ack_enable: assert property (
    en && phase_reg == wait_ack_pkg::PH_ADDR && cnt_reg == 4'h8 && !ctrl_reg.master_mode
    && ext_flag_reg |=> SDA_OE_O == $past(ctrl_reg.ack_drive_enable))
    else $error("acknowledge after extension code ignores enable");
  a_release_clears: assert property (
    ctrl_reg.wait_release_request && !wait_set && !wr_acc
    |=> !ctrl_reg.wait_release_request && !wait_reg)
    else $error("wait release did not end wait or self-clear");
endmodule : wait_ack_ctrl

// ### verilog/wait_ack_pkg.sv
// constants and types for the two-wire bus wait and acknowledge control
package wait_ack_pkg;
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;
  localparam logic [3:0] CNT_EIGHTH   = 4'h7;
  localparam logic [3:0] CNT_NINTH    = 4'h8;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam int INT_XFER  = 0;
  localparam int INT_START = 1;
  localparam int INT_STOP  = 2;
  localparam int NUM_INT   = 3;

  typedef struct packed {
    logic tx_dir;
    logic master_mode;
    logic wait_release_request;
    logic ack_drive_enable;
    logic wait_point_select;
    logic bus_unit_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 6'h00;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } phase_t;
endpackage : wait_ack_pkg
